/* include/smc_pkg.sv */
package smc_pkg;

  // APB address width and register indices; byte address is four times index.
  localparam int APB_AW = 20;
  localparam logic [15:0] IDX_OSC_CTRL = 16'hFE0E;
  localparam logic [15:0] IDX_PWR_CTRL = 16'hFE10;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hFE11;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hFE12;
  localparam logic [19:0] ADDR_OSC_CTRL = {2'h0, IDX_OSC_CTRL, 2'h0};
  localparam logic [19:0] ADDR_PWR_CTRL = {2'h0, IDX_PWR_CTRL, 2'h0};
  localparam logic [19:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
  localparam logic [19:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

  // Power-control fields.
  localparam int PC_IDLE = 0;
  localparam int PC_STOP = 1;
  localparam int PC_XTAL_HOLD = 2;
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam logic [7:0] PC_WR_MASK = 8'h07;

  // Oscillation-control fields; bit 7 reads the crystal output pin level, bit 6 reads the input pin level only while OC_XT_EN is clear.
  localparam int OC_CF_EN = 0;
  localparam int OC_XT_EN = 1;
  localparam int OC_XT_FB = 2;
  localparam int OC_RC_EN = 3;
  localparam int OC_BT_RC = 4;
  localparam int OC_XT1_LVL = 6;
  localparam int OC_XT2_LVL = 7;
  localparam logic [7:0] OC_RESET = 8'h01;
  localparam logic [7:0] OC_WR_MASK = 8'h1F;

  // Interrupt events.
  localparam int EV_STOP_WAKE = 0;
  localparam int EV_IDLE_EXIT = 1;
  localparam int EV_STBY_RESET = 2;
  localparam int EV_W = 3;

  // External interrupt lines that may end deep stop (lines 0-2, 4, 5).
  localparam logic [5:0] EXT_WAKE_MASK = 6'h37;
  localparam int SYNC_W = 3;

  typedef enum logic [2:0] {
    MODE_RESET,
    MODE_NORMAL,
    MODE_IDLE,
    MODE_STOP,
    MODE_XSTOP
  } smc_mode_t;

endpackage

/* core/smc_sync.sv */
`timescale 1ns/1ps
module smc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_synced;

  // Two flip-flops per bit; only the second stage is read outside.
  always_comb
  begin
    next_stage1 = async;
    next_synced = stage1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      stage1 <= INIT;
      synced <= INIT;
    end
    else
    begin
      stage1 <= next_stage1;
      synced <= next_synced;
    end
  end

endmodule

/* core/smc_irq.sv */
`timescale 1ns/1ps
module smc_irq #(
  parameter int WIDTH = 3
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] events,
  input wire logic clearWrite,
  input wire logic maskWrite,
  input wire logic [WIDTH-1:0] wrData,
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);

  logic [WIDTH-1:0] next_status;
  logic [WIDTH-1:0] next_mask;

  // Sticky status cleared by writing ones; a new event wins over a clear.
  always_comb
  begin
    next_status = status;
    next_mask = mask;
    if (clearWrite)
    begin
      next_status = status & ~wrData;
    end
    next_status = next_status | events;
    if (maskWrite)
    begin
      next_mask = wrData;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      status <= '0;
      mask <= '0;
    end
    else
    begin
      status <= next_status;
      mask <= next_mask;
    end
  end

  // Level interrupt while any unmasked status bit is set.
  assign irq = |(status & mask);

endmodule

/* core/smc_top.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module smc_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [smc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic externalResetPinN,
  input wire logic wdtReset,
  input wire logic wdtRcRequest,
  input wire logic [5:0] externalInterrupt,
  input wire logic port0Irq,
  input wire logic usbHostControllerBusActive,
  input wire logic baseTimerIrq,
  input wire logic remoteIrq,
  input wire logic anyIrqAccepted,
  input wire logic baseTimerRunning,
  input wire logic crystalInputPin,
  input wire logic crystalOutputPin,
  output logic cpuRun,
  output logic periphRun,
  output logic serialUsbPartRun,
  output logic remoteRun,
  output logic baseTimerClkEn,
  output logic crystalOscEn,
  output logic crystalFeedbackEn,
  output logic crystalPinOscMode,
  output logic crystalOutputHoldHigh,
  output logic ceramicOscEn,
  output logic ceramicOutputHoldHigh,
  output logic rcOscEn,
  output logic irq
);
  import smc_pkg::*;

  smc_mode_t mode, next_mode;
  logic [7:0] powerControl, next_powerControl;
  logic [7:0] oscillationControl, next_oscillationControl;
  logic next_cpuRun, next_periphRun, next_serialUsbPartRun, next_remoteRun;
  logic next_baseTimerClkEn, next_crystalOscEn, next_crystalFeedbackEn;
  logic next_crystalPinOscMode, next_crystalOutputHoldHigh;
  logic next_ceramicOscEn, next_ceramicOutputHoldHigh, next_rcOscEn;
  logic [31:0] next_prdata;
  logic [SYNC_W-1:0] pinSync;
  logic resetPinN, xtInLevel, xtOutLevel;
  logic rstCond, deepWake, holdWake, setupPhase, writeDone, mapped;
  logic [EV_W-1:0] events, irqStatus, irqMask;

  // The reset pin and both crystal pins pass two flip-flops; wake inputs are used unsynchronised.
  smc_sync #(.WIDTH(SYNC_W), .INIT(3'h1)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async({crystalOutputPin, crystalInputPin, externalResetPinN}),
    .synced(pinSync)
  );
  assign resetPinN = pinSync[0];
  assign xtInLevel = pinSync[1];
  assign xtOutLevel = pinSync[2];

  // Reset conditions and wake sources for the two stop modes.
  assign rstCond = !resetPinN || wdtReset;
  assign deepWake = |(externalInterrupt & EXT_WAKE_MASK) || port0Irq
    || usbHostControllerBusActive;
  assign holdWake = deepWake || baseTimerIrq || remoteIrq;

  // APB decode; zero wait states, error on unmapped addresses.
  assign pready = 1'b1;
  assign setupPhase = psel && !penable;
  assign mapped = (paddr == ADDR_OSC_CTRL) || (paddr == ADDR_PWR_CTRL)
    || (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK);
  assign pslverr = psel && penable && !mapped;
  assign writeDone = psel && penable && pwrite && mapped;

  // Mode sequencing, register updates and per-mode gating.
  always_comb
  begin
    next_mode = mode;
    next_powerControl = powerControl;
    next_oscillationControl = oscillationControl;
    events = '0;
    if (writeDone && paddr == ADDR_PWR_CTRL)
    begin
      next_powerControl = pwdata[7:0] & PC_WR_MASK;
    end
    if (writeDone && paddr == ADDR_OSC_CTRL)
    begin
      next_oscillationControl = pwdata[7:0] & OC_WR_MASK;
    end
    case (mode)
      MODE_RESET:
      begin
        next_powerControl = PC_RESET;
        next_oscillationControl = OC_RESET;
        if (!rstCond)
        begin
          next_mode = MODE_NORMAL;
        end
      end
      MODE_NORMAL:
      begin
        if (rstCond)
        begin
          next_mode = MODE_RESET;
        end
        else if (powerControl[PC_STOP])
        begin
          next_mode = powerControl[PC_XTAL_HOLD] ? MODE_XSTOP : MODE_STOP;
        end
        else if (powerControl[PC_IDLE])
        begin
          next_mode = MODE_IDLE;
        end
      end
      MODE_IDLE:
      begin
        if (rstCond)
        begin
          next_mode = MODE_RESET;
          events[EV_STBY_RESET] = 1'b1;
        end
        else if (anyIrqAccepted)
        begin
          next_mode = MODE_NORMAL;
          next_powerControl[PC_IDLE] = 1'b0;
          events[EV_IDLE_EXIT] = 1'b1;
        end
      end
      MODE_STOP, MODE_XSTOP:
      begin
        if (rstCond)
        begin
          next_mode = MODE_RESET;
          events[EV_STBY_RESET] = 1'b1;
        end
        else if (mode == MODE_STOP ? deepWake : holdWake)
        begin
          next_mode = MODE_IDLE;
          next_powerControl[PC_STOP] = 1'b0;
          events[EV_STOP_WAKE] = 1'b1;
        end
      end
      default:
      begin
        next_mode = MODE_RESET;
      end
    endcase
    next_cpuRun = (next_mode == MODE_NORMAL);
    next_serialUsbPartRun = (next_mode == MODE_NORMAL);
    next_periphRun = (next_mode == MODE_NORMAL)
      || (next_mode == MODE_IDLE);
    next_remoteRun = (next_mode != MODE_RESET)
      && (next_mode != MODE_STOP);
    next_baseTimerClkEn = next_remoteRun;
    next_crystalPinOscMode = ((next_mode == MODE_NORMAL)
      || (next_mode == MODE_IDLE)) && next_oscillationControl[OC_XT_EN];
    next_crystalOscEn = next_oscillationControl[OC_XT_EN]
      && next_remoteRun;
    next_crystalFeedbackEn = next_oscillationControl[OC_XT_FB]
      && (next_mode != MODE_RESET);
    next_crystalOutputHoldHigh = (next_mode == MODE_STOP)
      && next_oscillationControl[OC_XT_EN];
    next_ceramicOscEn = (next_mode == MODE_RESET)
      || (next_periphRun && next_oscillationControl[OC_CF_EN]);
    next_ceramicOutputHoldHigh = !next_ceramicOscEn;
    if (next_mode == MODE_XSTOP && oscillationControl[OC_BT_RC]
        && baseTimerRunning)
    begin
      next_rcOscEn = rcOscEn || wdtRcRequest;
    end
    else if (next_periphRun)
    begin
      next_rcOscEn = next_oscillationControl[OC_RC_EN] || wdtRcRequest;
    end
    else
    begin
      next_rcOscEn = wdtRcRequest && (next_mode != MODE_RESET);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      mode <= MODE_RESET;
      powerControl <= PC_RESET;
      oscillationControl <= OC_RESET;
      cpuRun <= 1'b0;
      periphRun <= 1'b0;
      serialUsbPartRun <= 1'b0;
      remoteRun <= 1'b0;
      baseTimerClkEn <= 1'b0;
      crystalOscEn <= 1'b0;
      crystalFeedbackEn <= 1'b0;
      crystalPinOscMode <= 1'b0;
      crystalOutputHoldHigh <= 1'b0;
      ceramicOscEn <= 1'b1;
      ceramicOutputHoldHigh <= 1'b0;
      rcOscEn <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      powerControl <= next_powerControl;
      oscillationControl <= next_oscillationControl;
      cpuRun <= next_cpuRun;
      periphRun <= next_periphRun;
      serialUsbPartRun <= next_serialUsbPartRun;
      remoteRun <= next_remoteRun;
      baseTimerClkEn <= next_baseTimerClkEn;
      crystalOscEn <= next_crystalOscEn;
      crystalFeedbackEn <= next_crystalFeedbackEn;
      crystalPinOscMode <= next_crystalPinOscMode;
      crystalOutputHoldHigh <= next_crystalOutputHoldHigh;
      ceramicOscEn <= next_ceramicOscEn;
      ceramicOutputHoldHigh <= next_ceramicOutputHoldHigh;
      rcOscEn <= next_rcOscEn;
    end
  end

  // Read data is captured in the setup cycle and held for the access cycle.
  always_comb
  begin
    next_prdata = prdata;
    if (setupPhase)
    begin
      next_prdata = 32'h0000_0000;
      if (paddr == ADDR_OSC_CTRL)
      begin
        next_prdata[7:0] = oscillationControl;
        next_prdata[OC_XT1_LVL] = xtInLevel
          && !oscillationControl[OC_XT_EN];
        next_prdata[OC_XT2_LVL] = xtOutLevel;
      end
      else if (paddr == ADDR_PWR_CTRL)
      begin
        next_prdata[7:0] = powerControl;
      end
      else if (paddr == ADDR_IRQ_STAT)
      begin
        next_prdata[EV_W-1:0] = irqStatus;
      end
      else if (paddr == ADDR_IRQ_MASK)
      begin
        next_prdata[EV_W-1:0] = irqMask;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else
    begin
      prdata <= next_prdata;
    end
  end

  // Sticky event flags with mask and one level interrupt.
  smc_irq #(.WIDTH(EV_W)) u_irq (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .events(events),
    .clearWrite(writeDone && paddr == ADDR_IRQ_STAT),
    .maskWrite(writeDone && paddr == ADDR_IRQ_MASK),
    .wrData(pwdata[EV_W-1:0]),
    .status(irqStatus),
    .mask(irqMask),
    .irq(irq)
  );

  // Checks on mode transitions and gating.
  sequence s_deep_wake;
    mode == MODE_STOP && deepWake && !rstCond;
  endsequence
  sequence s_back_idle;
    mode == MODE_IDLE && !powerControl[PC_STOP] && !cpuRun;
  endsequence

  property p_rst_to_reset;
    @(posedge ref_clk) disable iff (!resetn)
    rstCond && mode != MODE_RESET |=> mode == MODE_RESET;
  endproperty
  a_rst_to_reset: assert property (p_rst_to_reset)
    else $error("Reset condition did not enter reset state.");

  property p_stop_wake;
    @(posedge ref_clk) disable iff (!resetn)
    s_deep_wake |=> s_back_idle;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("Deep stop wake did not return to idle.");

  property p_stop_hold;
    @(posedge ref_clk) disable iff (!resetn)
    mode == MODE_STOP && !deepWake && !rstCond |=> mode == MODE_STOP;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("Deep stop left without wake source.");

  property p_xstop_timer;
    @(posedge ref_clk) disable iff (!resetn)
    mode == MODE_XSTOP && baseTimerIrq && !rstCond |=> mode == MODE_IDLE;
  endproperty
  a_xstop_timer: assert property (p_xstop_timer)
    else $error("Base timer did not wake crystal stop.");

  property p_idle_exit;
    @(posedge ref_clk) disable iff (!resetn)
    mode == MODE_IDLE && anyIrqAccepted && !rstCond
      |=> mode == MODE_NORMAL && !powerControl[PC_IDLE] && cpuRun;
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("Idle exit did not reach normal or clear bit 0.");

  property p_gating;
    @(posedge ref_clk) disable iff (!resetn)
    (mode == MODE_STOP |-> !remoteRun && !periphRun)
      and (mode == MODE_XSTOP |-> remoteRun && !periphRun);
  endproperty
  a_gating: assert property (p_gating)
    else $error("Peripheral gating wrong in a stop mode.");

  property p_idle_part;
    @(posedge ref_clk) disable iff (!resetn)
    mode == MODE_IDLE |-> periphRun && !serialUsbPartRun;
  endproperty
  a_idle_part: assert property (p_idle_part)
    else $error("Idle gating of serial and USB part wrong.");

  property p_xt1_read;
    @(posedge ref_clk) disable iff (!resetn)
    setupPhase && paddr == ADDR_OSC_CTRL && oscillationControl[OC_XT_EN]
      |=> !prdata[OC_XT1_LVL];
  endproperty
  a_xt1_read: assert property (p_xt1_read)
    else $error("Crystal input level read nonzero while oscillating.");

  property p_reset_exit;
    @(posedge ref_clk) disable iff (!resetn)
    mode == MODE_RESET && !rstCond |=> mode == MODE_NORMAL;
  endproperty
  a_reset_exit: assert property (p_reset_exit)
    else $error("Reset state not left after conditions cancelled.");

  property p_rc_wdt;
    @(posedge ref_clk) disable iff (!resetn)
    wdtRcRequest && !rstCond && mode != MODE_RESET |=> rcOscEn;
  endproperty
  a_rc_wdt: assert property (p_rc_wdt)
    else $error("Watchdog request did not run RC oscillator.");

  property p_cf_hold;
    @(posedge ref_clk) disable iff (!resetn)
    mode == MODE_STOP ##1 mode == MODE_STOP |-> ceramicOutputHoldHigh;
  endproperty
  a_cf_hold: assert property (p_cf_hold)
    else $error("Ceramic output not held high while suspended.");

endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import smc_pkg::*;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic externalResetPinN, wdtReset, wdtRcRequest, anyIrqAccepted;
  logic baseTimerRunning, crystalInputPin, crystalOutputPin;
  logic cpuRun, periphRun, serialUsbPartRun, remoteRun, baseTimerClkEn;
  logic crystalOscEn, crystalFeedbackEn, crystalPinOscMode, rcOscEn, irq;
  logic crystalOutputHoldHigh, ceramicOscEn, ceramicOutputHoldHigh;
  logic [9:0] wakeSrc;
  logic [3:0] runs;
  int num_errors = 0;
  int total_checks = 0;

  // Wake sources: lines 0..5, port 0, bus activity, base timer, remote.
  assign runs = {cpuRun, periphRun, serialUsbPartRun, remoteRun};

  smc_top dut (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .externalResetPinN, .wdtReset,
    .wdtRcRequest, .externalInterrupt(wakeSrc[5:0]), .port0Irq(wakeSrc[6]),
    .usbHostControllerBusActive(wakeSrc[7]), .baseTimerIrq(wakeSrc[8]),
    .remoteIrq(wakeSrc[9]), .anyIrqAccepted, .baseTimerRunning,
    .crystalInputPin, .crystalOutputPin, .cpuRun, .periphRun,
    .serialUsbPartRun, .remoteRun, .baseTimerClkEn, .crystalOscEn,
    .crystalFeedbackEn, .crystalPinOscMode, .crystalOutputHoldHigh,
    .ceramicOscEn, .ceramicOutputHoldHigh, .rcOscEn, .irq);

  // Free-running 10 MHz clock.
  initial
  begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Register value comparison.
  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Output flag group comparison.
  task automatic chkBits(input logic [3:0] got, exp, input string what);
    chk({28'h0, got}, {28'h0, exp}, what);
  endtask

  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic wr, input logic [19:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic err);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    // The wait ends when pready is seen high; only the watchdog ends a wait that never sees it.
    while (pready !== 1'h1)
    begin
      @(posedge ref_clk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask

  task automatic rdChk(input logic [19:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'h0, a, 32'h0, q, e);
    chk(q, exp, "read data");
    chkBits({3'h0, e}, 4'h0, "slave error");
  endtask

  // Wake from idle through an accepted interrupt.
  task automatic accept();
    anyIrqAccepted <= 1'h1;
    cyc(2);
    anyIrqAccepted <= 1'h0;
    cyc(1);
  endtask

  // Reset values, pin levels and an unmapped access.
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rdChk(ADDR_OSC_CTRL, 32'hC1);
    {crystalInputPin, crystalOutputPin} <= 2'h0;
    cyc(2);
    rdChk(ADDR_OSC_CTRL, 32'h01);
    {crystalInputPin, crystalOutputPin} <= 2'h3;
    cyc(2);
    chkBits({3'h0, pready}, 4'h1, "ready level");
    rdChk(ADDR_PWR_CTRL, 32'h00);
    apb(1'h0, 20'h00010, 32'h0, q, e);
    chk(q, 32'h0, "unmapped read");
    chkBits({3'h0, e}, 4'h1, "unmapped error");
    chkBits(runs, 4'hF, "normal run");
    chkBits({3'h0, irq}, 4'h0, "irq idle");
  endtask

  // Idle entry, gating, pin reads, exit and interrupt handling.
  task automatic t_idle();
    wr(ADDR_IRQ_MASK, 32'h00);
    wr(ADDR_OSC_CTRL, 32'h03);
    wr(ADDR_PWR_CTRL, 32'h01);
    cyc(2);
    chkBits(runs, 4'h5, "idle run");
    chkBits({3'h0, crystalPinOscMode}, 4'h1, "xtal pins");
    rdChk(ADDR_OSC_CTRL, 32'h83);
    accept();
    chkBits(runs, 4'hF, "idle exit");
    rdChk(ADDR_PWR_CTRL, 32'h00);
    chkBits({3'h0, irq}, 4'h0, "masked irq");
    wr(ADDR_IRQ_MASK, 32'h07);
    cyc(1);
    chkBits({3'h0, irq}, 4'h1, "unmasked irq");
    rdChk(ADDR_IRQ_STAT, 32'h02);
    wr(ADDR_IRQ_STAT, 32'h02);
    cyc(1);
    rdChk(ADDR_IRQ_STAT, 32'h00);
    chkBits({3'h0, irq}, 4'h0, "cleared irq");
  endtask

  // Try each wake source against one stop mode.
  task automatic t_wake(input logic [7:0] pc, input logic [9:0] ok,
    input logic [3:0] runStop);
    for (int k = 0; k < 10; k++)
    begin
      wr(ADDR_PWR_CTRL, {24'h0, pc});
      cyc(2);
      chkBits(runs, runStop, "stop run");
      chkBits({2'h0, ceramicOscEn, ceramicOutputHoldHigh}, 4'h1,
        "ceramic hold");
      chkBits({baseTimerClkEn, crystalOutputHoldHigh, crystalOscEn,
        crystalFeedbackEn}, pc[2] ? 4'hA : 4'h4, "stop clocks");
      wakeSrc <= 10'h1 << k;
      cyc(3);
      wakeSrc <= 10'h0;
      chkBits(runs, ok[k] ? 4'h5 : runStop, "wake");
      if (ok[k])
      begin
        rdChk(ADDR_PWR_CTRL, {24'h0, pc & 8'hFD});
      end
      wakeSrc <= 10'h1;
      cyc(2);
      wakeSrc <= 10'h0;
      accept();
      chkBits(runs, 4'hF, "back to normal");
    end
    wr(ADDR_IRQ_STAT, 32'h07);
  endtask

  // Oscillator gating by software, watchdog and crystal stop.
  task automatic t_osc();
    wr(ADDR_OSC_CTRL, 32'h00);
    cyc(2);
    chkBits({3'h0, ceramicOutputHoldHigh}, 4'h1, "ceramic off");
    chkBits({3'h0, rcOscEn}, 4'h0, "rc off");
    wdtRcRequest <= 1'h1;
    cyc(2);
    chkBits({3'h0, rcOscEn}, 4'h1, "rc by watchdog");
    wdtRcRequest <= 1'h0;
    baseTimerRunning <= 1'h1;
    wr(ADDR_OSC_CTRL, 32'h19);
    wr(ADDR_PWR_CTRL, 32'h06);
    cyc(2);
    chkBits({3'h0, rcOscEn}, 4'h1, "rc kept");
    wakeSrc <= 10'h1;
    cyc(2);
    wakeSrc <= 10'h0;
    accept();
    baseTimerRunning <= 1'h0;
    wr(ADDR_IRQ_STAT, 32'h07);
  endtask

  // Reset conditions during standby and by the pin.
  task automatic t_stbyReset();
    wr(ADDR_OSC_CTRL, 32'h07);
    wr(ADDR_PWR_CTRL, 32'h01);
    cyc(2);
    chkBits({3'h0, crystalFeedbackEn}, 4'h1, "feedback on");
    wdtReset <= 1'h1;
    cyc(2);
    chkBits(runs, 4'h0, "standby reset");
    chkBits({3'h0, crystalFeedbackEn}, 4'h0, "feedback off");
    wdtReset <= 1'h0;
    cyc(3);
    chkBits(runs, 4'hF, "reset exit");
    rdChk(ADDR_OSC_CTRL, 32'hC1);
    rdChk(ADDR_IRQ_STAT, 32'h04);
    wr(ADDR_IRQ_STAT, 32'h04);
    externalResetPinN <= 1'h0;
    cyc(4);
    chkBits(runs, 4'h0, "pin reset");
    externalResetPinN <= 1'h1;
    cyc(5);
    chkBits(runs, 4'hF, "pin release");
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog against a hung run.
  initial
  begin
    #2000000;
    num_errors++;
    final_report();
  end

  // Main sequence.
  initial
  begin
    resetn = 1'h0;
    {psel, penable, pwrite, wdtReset, wdtRcRequest} = 5'h00;
    {anyIrqAccepted, baseTimerRunning} = 2'h0;
    {externalResetPinN, crystalInputPin, crystalOutputPin} = 3'h7;
    paddr = '0;
    pwdata = 32'h0;
    wakeSrc = 10'h0;
    cyc(16);
    resetn <= 1'h1;
    cyc(4);
    t_reset();
    t_idle();
    t_wake(8'h02, 10'h0F7, 4'h0);
    t_wake(8'h06, 10'h3F7, 4'h1);
    t_osc();
    t_stbyReset();
    final_report();
  end
endmodule
